/* cdt_pkg.sv */
// Package: constants and types shared by the countdown timer block
package cdt_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int NUM_TIMERS    = 3;
    localparam int COUNT_W       = 32;
    localparam int PRESCALE_W    = 16;
    localparam int GROUP_SIZE    = 8;
    localparam int CPU_LINES     = 12;
    localparam int CPU_LINE_BASE = 13;
    localparam int TIMER0_GROUP_SLOT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    // Zero period keeps a timer reloading and flagging until software presets one;
    // a full-scale start would never reach its first reload in practice
    localparam logic [COUNT_W-1:0]    COUNT_RESET    = 32'h00000000;
    localparam logic [COUNT_W-1:0]    PERIOD_RESET   = 32'h00000000;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Clock source of timer 2
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CDT_SRC_SYSCLK = 2'h0,
        CDT_SRC_OSC1   = 2'h1,
        CDT_SRC_OSC2   = 2'h2,
        CDT_SRC_EXT    = 2'h3
    } cdt_src_type;

    localparam cdt_src_type SRC_RESET = CDT_SRC_SYSCLK;

endpackage : cdt_pkg

/* cdt_timers.sv */
// Module: three 32-bit countdown timers with prescalers and auto-reload
// Functional notes
// - Three identical timers each hold a 32-bit down counter whose period software presets.
// - Each counter decrements once per tick, the CPU clock (timer 2: its selected source) divided by a 16-bit prescale setting plus one.
// - A timer raises its interrupt request on the tick that reloads its counter from zero.
// - At zero the counter reloads the stored period and keeps counting by itself.
// - Timer 0 interrupt goes to the interrupt expansion block, not straight to a CPU line.
// - Timer 1 interrupt is connectable to CPU interrupt line 13.
// - Timer 2 interrupt drives CPU interrupt line 14.
// - Timer 2 counts from system clock output (default), oscillator one, oscillator two or an external clock.
// - The expansion block groups sources by 8, each group feeding one of 12 CPU lines.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// One timer: prescaler, down counter, period and sticky zero flag
// ----------------------------------------------------------------------
module cdt_timer_unit
    import cdt_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Count clock qualifier
    input  wire logic                  src_edge,
    // Configuration and control
    input  wire logic                  period_wr,
    input  wire logic [COUNT_W-1:0]    period_data,
    input  wire logic [PRESCALE_W-1:0] prescale_set,
    input  wire logic                  flag_clr,
    // Status
    output logic [COUNT_W-1:0]         count,
    output logic                       flag
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [COUNT_W-1:0]    count;
        logic [COUNT_W-1:0]    period;
        logic [PRESCALE_W-1:0] pre;
        logic                  flag;
    } cdt_unit_state_type;

    cdt_unit_state_type st_r;
    cdt_unit_state_type st_nxt;

    logic                  tick;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        tick   = 1'b0;
        // The counter is not touched; the new period applies at the next reload
        if (period_wr) begin
            st_nxt.period = period_data;
        end
        // Prescaler counts source edges; a slow source stretches every tick
        if (src_edge) begin
            if (st_r.pre == '0) begin
                st_nxt.pre = prescale_set;
                tick       = 1'b1;
            end else begin
                st_nxt.pre = st_r.pre - 16'h0001;
            end
        end
        if (tick) begin
            if (st_r.count == '0) begin
                st_nxt.count = st_r.period;
            end else begin
                st_nxt.count = st_r.count - 32'h00000001;
            end
        end
        // Set wins over a clear arriving in the same cycle
        if (flag_clr) begin
            st_nxt.flag = 1'b0;
        end
        if (tick && (st_r.count == '0)) begin
            st_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.count  <= COUNT_RESET;
            st_r.period <= PERIOD_RESET;
            st_r.pre    <= PRESCALE_RESET;
            st_r.flag   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        count = st_r.count;
        flag  = st_r.flag;
    end

endmodule // cdt_timer_unit

// ----------------------------------------------------------------------
// Top: three timers, timer 2 source selection and interrupt routing
// ----------------------------------------------------------------------
module cdt_timers
    import cdt_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Per-timer configuration and control
    input  wire logic [NUM_TIMERS-1:0]          period_wr,
    input  wire logic [NUM_TIMERS*COUNT_W-1:0]  period_data,
    input  wire logic [NUM_TIMERS*PRESCALE_W-1:0] prescale_set,
    input  wire logic [NUM_TIMERS-1:0]          flag_clr,
    // Timer 2 clock source
    input  wire logic [1:0]                     t2_src_sel,
    input  wire logic                           internal_oscillator_one,
    input  wire logic                           internal_oscillator_two,
    input  wire logic                           ext_clock_in,
    // Timer 1 routing
    input  wire logic                           t1_route_en,
    // Status
    output logic [NUM_TIMERS*COUNT_W-1:0]       count_out,
    output logic [NUM_TIMERS-1:0]               zero_flag,
    // Interrupt outputs
    output logic [GROUP_SIZE-1:0]               interrupt_expansion_block,
    output logic                                cpu_irq_line_thirteen,
    output logic                                cpu_irq_line_fourteen
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                            osc1_sync;
        logic [2:0]                            osc2_sync;
        logic [2:0]                            ext_sync;
        cdt_src_type                           src;
    } cdt_state_type;

    cdt_state_type st_r;
    cdt_state_type st_nxt;

    logic                  src_edge;
    logic [NUM_TIMERS-1:0] run_en;
    logic [COUNT_W-1:0]    unit_count [NUM_TIMERS];
    logic                  unit_flag  [NUM_TIMERS];

    // ------------------------------------------------------------------
    // Timer 2 source edge
    // ------------------------------------------------------------------
    // Bit 0 is the first sync stage; only bits 1 and 2 are looked at
    always_comb begin
        unique case (st_r.src)
            CDT_SRC_SYSCLK: src_edge = 1'b1;
            CDT_SRC_OSC1:   src_edge = st_r.osc1_sync[1] & ~st_r.osc1_sync[2];
            CDT_SRC_OSC2:   src_edge = st_r.osc2_sync[1] & ~st_r.osc2_sync[2];
            CDT_SRC_EXT:    src_edge = st_r.ext_sync[1] & ~st_r.ext_sync[2];
        endcase
    end

    // ------------------------------------------------------------------
    // Source synchronisers and selection
    // ------------------------------------------------------------------
    // Sources must run below half the clock rate or edges are lost
    always_comb begin
        st_nxt           = st_r;
        st_nxt.osc1_sync = {st_r.osc1_sync[1:0], internal_oscillator_one};
        st_nxt.osc2_sync = {st_r.osc2_sync[1:0], internal_oscillator_two};
        st_nxt.ext_sync  = {st_r.ext_sync[1:0], ext_clock_in};
        st_nxt.src       = cdt_src_type'(t2_src_sel);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.osc1_sync <= '0;
            st_r.osc2_sync <= '0;
            st_r.ext_sync  <= '0;
            st_r.src       <= SRC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    // Timers 0 and 1 run on every clock; timer 2 waits for its source
    always_comb begin
        run_en               = '1;
        run_en[NUM_TIMERS-1] = src_edge;
    end

    for (genvar g = 0; g < NUM_TIMERS; g++) begin : gen_timer
        cdt_timer_unit timer_u (
            .clk          (clk),
            .rst          (rst),
            .src_edge     (run_en[g]),
            .period_wr    (period_wr[g]),
            .period_data  (period_data[g*COUNT_W +: COUNT_W]),
            .prescale_set (prescale_set[g*PRESCALE_W +: PRESCALE_W]),
            .flag_clr     (flag_clr[g]),
            .count        (unit_count[g]),
            .flag         (unit_flag[g])
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            count_out[i*COUNT_W +: COUNT_W] = unit_count[i];
            zero_flag[i]                    = unit_flag[i];
        end
        interrupt_expansion_block = '0;
        interrupt_expansion_block[TIMER0_GROUP_SLOT] = unit_flag[0];
        cpu_irq_line_thirteen = unit_flag[1] & t1_route_en;
        cpu_irq_line_fourteen = unit_flag[2];
    end

endmodule // cdt_timers

/* cdt_timers_asserts.sv */
// Checker: port-level properties of the countdown timers
`timescale 1ns/1ps
module cdt_chk
    import cdt_pkg::*;
(
    // Inputs
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic [NUM_TIMERS-1:0]         flag_clr,
    input wire logic                          t1_route_en,
    input wire logic [1:0]                    t2_src_sel,
    input wire logic                          ext_clock_in,
    // Outputs
    input wire logic [NUM_TIMERS*COUNT_W-1:0] count_out,
    input wire logic [NUM_TIMERS-1:0]         zero_flag,
    input wire logic [GROUP_SIZE-1:0]         interrupt_expansion_block,
    input wire logic                          cpu_irq_line_thirteen,
    input wire logic                          cpu_irq_line_fourteen
);
    wire logic [31:0] c0 = count_out[31:0];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_dec_step: assert property (c0 != 0 |=> $past(c0) - c0 <= 32'h1) else $error("count moved by more than one");
    a_reload_flag: assert property (c0 == 0 ##1 c0 != 0 |-> zero_flag[0]) else $error("reload without flag");
    a_flag_hold: assert property (zero_flag[0] && !flag_clr[0] |=> zero_flag[0]) else $error("flag lost");
    a_flag_cause: assert property ($rose(zero_flag[1]) |-> $past(count_out[63:32]) == 0) else $error("flag early");
    a_t0_route: assert property (interrupt_expansion_block == {7'h00, zero_flag[0]}) else $error("group slot");
    a_t1_route: assert property (cpu_irq_line_thirteen == (zero_flag[1] & t1_route_en)) else $error("line 13");
    a_t2_route: assert property (cpu_irq_line_fourteen == zero_flag[2]) else $error("line 14");
    a_t2_ext_hold: assert property ((t2_src_sel == 2'h3 && !ext_clock_in)[*5] |=> $stable(count_out[95:64]))
        else $error("timer 2 counted without edges");
endmodule // cdt_chk
bind cdt_timers cdt_chk chk_u (.clk, .rst, .flag_clr, .t1_route_en, .t2_src_sel, .ext_clock_in, .count_out,
    .zero_flag, .interrupt_expansion_block, .cpu_irq_line_thirteen, .cpu_irq_line_fourteen);

/* cdt_cpu_model.sv */
// Partner model: CPU side that acknowledges timer interrupts
`timescale 1ns/1ps
module cdt_cpu_model
    import cdt_pkg::*;
(
    // Interrupt lines in
    input wire logic                  clk,
    input wire logic [GROUP_SIZE-1:0] interrupt_expansion_block,
    input wire logic                  cpu_irq_line_thirteen,
    input wire logic                  cpu_irq_line_fourteen,
    // Acknowledge out
    output logic [NUM_TIMERS-1:0]     flag_clr
);
    // One-cycle clear pulse, as a handler would issue after entry
    initial flag_clr = '0;
    always @(posedge clk) flag_clr <= #1 {cpu_irq_line_fourteen, cpu_irq_line_thirteen,
        interrupt_expansion_block[TIMER0_GROUP_SLOT]} & ~flag_clr;
endmodule // cdt_cpu_model

/* tb.sv */
// Testbench: reset values, prescaled decrement and timer 2 clock sources
`timescale 1ns/1ps
module tb;
    import cdt_pkg::*;
    logic                           clk = 1'b0, rst = 1'b1, t1_en = 1'b1, i13, i14;
    logic [NUM_TIMERS-1:0]          wr = '0, clr, flag;
    logic [NUM_TIMERS*COUNT_W-1:0]  pdata = '0, cnt;
    logic [NUM_TIMERS*PRESCALE_W-1:0] pre = '0;
    logic [1:0]                     sel = 2'h0;
    logic [2:0]                     src = 3'h0;
    logic [GROUP_SIZE-1:0]          ieb;
    int                             failures = 0, n_compared = 0, cyc = 0;
    initial forever #50 clk = ~clk;
    cdt_timers dut_u (.clk, .rst, .period_wr(wr), .period_data(pdata), .prescale_set(pre), .flag_clr(clr),
        .t2_src_sel(sel), .internal_oscillator_one(src[0]), .internal_oscillator_two(src[1]),
        .ext_clock_in(src[2]), .t1_route_en(t1_en), .count_out(cnt), .zero_flag(flag),
        .interrupt_expansion_block(ieb), .cpu_irq_line_thirteen(i13), .cpu_irq_line_fourteen(i14));
    cdt_cpu_model cpu_u (.clk, .interrupt_expansion_block(ieb), .cpu_irq_line_thirteen(i13),
        .cpu_irq_line_fourteen(i14), .flag_clr(clr));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_reset();
        for (int i = 0; i < NUM_TIMERS; i++) check("count at reset", cnt[i*32+:32], COUNT_RESET);
        check("flags at reset", {29'h0, flag}, 32'h0);
        check("irq lines at reset", {22'h0, ieb, i13, i14}, 32'h0);
    endtask
    // Period 3 from a zero start: load at the first tick, reload with a flag four ticks later
    task automatic t_reload();
        tick(8);
        pdata = {3{32'h3}};
        wr = 3'h7;
        tick(1);
        wr = 3'h0;
        tick(4);
        for (int i = 0; i < NUM_TIMERS; i++) check("count at zero", cnt[i*32+:32], 32'h0);
        check("flags cleared by handler", {29'h0, flag}, 32'h0);
        tick(1);
        for (int i = 0; i < NUM_TIMERS; i++) check("count reloaded", cnt[i*32+:32], 32'h3);
        check("flags at zero", {29'h0, flag}, 32'h7);
        check("irq lines at zero", {22'h0, ieb, i13, i14}, 32'h7);
        t1_en = 1'b0;
        tick(1);
        check("line 13 gated", {31'h0, i13}, 32'h0);
        check("line 13 flag kept", {31'h0, flag[1]}, 32'h1);
    endtask
    // With prescale n, each timer must decrement six times in every window of 6*(n+1) clocks
    task automatic t_prescale(logic [15:0] n);
        logic [31:0] c;
        pre = {3{n}};
        wr = 3'h7;
        pdata = {3{32'h100}};
        tick(1);
        wr = 3'h0;
        tick(8);
        for (int i = 0; i < NUM_TIMERS; i++) begin
            c = cnt[i*32+:32];
            tick(6 * (n + 1));
            check("ticks per window", c - cnt[i*32+:32], 32'h6);
        end
    endtask
    task automatic t_source(logic [1:0] s);
        logic [31:0] c;
        pre = '0;
        tick(4);
        sel = s;
        tick(8);
        c = cnt[95:64];
        repeat (10) begin
            src[s-1] = 1'b1;
            tick(2);
            src[s-1] = 1'b0;
            tick(2);
        end
        tick(4);
        check("source edges counted", c - cnt[95:64], 32'h0A);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        tick(16);
        t_reset();
        rst = 1'b0;
        t_reload();
        t_prescale(16'h0000);
        t_prescale(16'h0002);
        for (int s = 1; s < 4; s++) t_source(s[1:0]);
        tally_and_finish();
    end
endmodule // tb
